// ==== hw/btft_framer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btft_cfg.svh"

module btft_framer #(
   parameter int MAX_STREAMS = 64,
   parameter int FIB_BYTES = 32,
   parameter logic [15:0] CRC_POLY = 16'h1021,
   parameter logic [15:0] CRC_PRESET = 16'hFFFF,
   parameter bit CRC_INVERT = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`BTFT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Upstream bytes
   input wire logic [7:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Downstream bytes
   output logic [7:0] outData,
   output logic outValid,
   input wire logic outReady,
   // Frame events
   output logic frameDone,
   output logic frameError
);

   localparam int SIW = $clog2(MAX_STREAMS);
   localparam logic [12:0] FIB_W = FIB_BYTES[12:0];

   btft_pkg::btft_state_t state;
   logic [13:0] hdrIdx;
   logic [13:0] descOff;
   logic [SIW-1:0] descSel;
   logic [SIW-1:0] strmSel;
   logic [10:0] streamCount;
   logic [10:0] nNow;
   logic [10:0] strm;
   logic [2:0] cntHi;
   logic [7:0] desc0;
   logic [12:0] lenMem [MAX_STREAMS];
   logic flagMem [MAX_STREAMS];
   logic [12:0] remain;
   logic [1:0] cnt;
   logic curFlag;
   logic [1:0] syncBlocks;
   logic [23:0] payloadLen;
   logic [15:0] frameCount;
   logic [31:0] tsLatch;
   logic [2:0] ctrl;
   logic [`BTFT_ST_W-1:0] status;
   logic [`BTFT_ST_W-1:0] evSet;
   logic [`BTFT_ST_W-1:0] frameAcc;
   logic [31:0] timeStamp;
   logic stIdle, stHead, stRsv, stHcrc, stLoad, stData, stScrc;
   logic stTrail, stStamp;
   logic verify, srcIn, genByte, room, advance;
   logic [15:0] crcOut;
   logic [7:0] crcSel;
   logic [7:0] byteSel;
   logic crcEn, crcInit;
   logic [12:0] loadLen;
   logic [12:0] blockCap;
   logic [2:0] dType;
   logic [2:0] dSub;
   logic apbWr, apbSetup;

   // Head end position for a given stream count
   function automatic logic [13:0] hdrLast(input logic [10:0] n);
      return {1'b0, n, 2'b00} + `BTFT_HEAD_TAIL;
   endfunction

   // Payload bytes of a stream, its own sum excluded
   function automatic logic [12:0] dataLen(input logic [12:0] len,
                                          input logic flag);
      return (flag && len >= 13'h0002) ? len - 13'h0002 : len;
   endfunction

   // State decode and byte flow
   assign stIdle = state == btft_pkg::S_IDLE;
   assign stHead = state == btft_pkg::S_HEAD;
   assign stRsv = state == btft_pkg::S_RSV;
   assign stHcrc = state == btft_pkg::S_HCRC;
   assign stLoad = state == btft_pkg::S_LOAD;
   assign stData = state == btft_pkg::S_DATA;
   assign stScrc = state == btft_pkg::S_SCRC;
   assign stTrail = state == btft_pkg::S_TRAIL;
   assign stStamp = state == btft_pkg::S_STAMP;
   assign verify = ctrl[`BTFT_CTRL_VERIFY];
   assign genByte = stRsv || stHcrc || stScrc || stTrail || stStamp;
   assign srcIn = stHead || stData || (verify && genByte);
   assign room = !outValid || outReady;
   assign inReady = room && srcIn;
   assign advance = room && (srcIn ? inValid : genByte);

   // Descriptor addressing and live stream count
   assign descOff = hdrIdx - `BTFT_POS_DESC;
   assign descSel = descOff[SIW+1:2];
   assign strmSel = strm[SIW-1:0];
   assign nNow = (hdrIdx == `BTFT_POS_CNT_LO) ? {cntHi, inData} : streamCount;
   assign loadLen = dataLen(lenMem[strmSel], flagMem[strmSel]);
   assign dType = desc0[7:5];
   assign dSub = inData[7:5];
   assign blockCap = ctrl[`BTFT_CTRL_MODE3] ? FIB_W * `BTFT_BLOCKS_MODE3
                                            : FIB_W * `BTFT_BLOCKS_STD;

   // Outgoing byte: passed through, zero, sum or stamp
   assign crcSel = cnt[0] ? crcOut[7:0] : crcOut[15:8];
   always_comb
   begin
      byteSel = inData;
      if (!verify)
      begin
         if (stRsv || stTrail)
            byteSel = 8'h00;
         else if (stHcrc || stScrc)
            byteSel = crcSel;
         else if (stStamp)
            byteSel = tsLatch[8*(3-cnt) +: 8];
      end
   end

   // Sum feeding: header span from byte ten, then each payload
   assign crcEn = advance && ((((stHead || stRsv) &&
                  hdrIdx >= `BTFT_POS_HCRC_FIRST)) || stData);
   assign crcInit = stIdle || stLoad;

   btft_crc16 #(
      .POLY(CRC_POLY),
      .PRESET(CRC_PRESET),
      .INVERT(CRC_INVERT)
   ) uCrc (
      .clk_sys(clk_sys),
      .reset(reset),
      .init(crcInit),
      .en(crcEn),
      .data(byteSel),
      .crcOut(crcOut)
   );

   // Frame sequencer
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state <= btft_pkg::S_IDLE;
         hdrIdx <= 14'h0000;
         cnt <= 2'h0;
         strm <= 11'h000;
         remain <= 13'h0000;
         curFlag <= 1'b0;
      end
      else
      begin
         case (state)
            btft_pkg::S_IDLE:
               if (ctrl[`BTFT_CTRL_EN])
               begin
                  state <= btft_pkg::S_HEAD;
                  hdrIdx <= 14'h0000;
               end
            btft_pkg::S_HEAD:
               if (advance)
               begin
                  hdrIdx <= hdrIdx + 14'h0001;
                  if (hdrIdx == hdrLast(nNow))
                     state <= btft_pkg::S_RSV;
               end
            btft_pkg::S_RSV:
               if (advance)
               begin
                  hdrIdx <= hdrIdx + 14'h0001;
                  cnt <= 2'h0;
                  if (hdrIdx == hdrLast(streamCount) + 14'h0002)
                     state <= btft_pkg::S_HCRC;
               end
            btft_pkg::S_HCRC:
               if (advance)
               begin
                  cnt <= cnt + 2'h1;
                  strm <= 11'h000;
                  if (cnt[0])
                     state <= btft_pkg::S_LOAD;
               end
            btft_pkg::S_LOAD:
            begin
               cnt <= 2'h0;
               curFlag <= flagMem[strmSel] && lenMem[strmSel] >= 13'h0002;
               remain <= loadLen;
               if (strm == streamCount)
                  state <= btft_pkg::S_TRAIL;
               else if (loadLen != 13'h0000)
                  state <= btft_pkg::S_DATA;
               else if (flagMem[strmSel] && lenMem[strmSel] >= 13'h0002)
                  state <= btft_pkg::S_SCRC;
               else
                  strm <= strm + 11'h001;
            end
            btft_pkg::S_DATA:
               if (advance)
               begin
                  remain <= remain - 13'h0001;
                  if (remain == 13'h0001)
                  begin
                     if (curFlag)
                        state <= btft_pkg::S_SCRC;
                     else
                     begin
                        state <= btft_pkg::S_LOAD;
                        strm <= strm + 11'h001;
                     end
                  end
               end
            btft_pkg::S_SCRC:
               if (advance)
               begin
                  cnt <= cnt + 2'h1;
                  if (cnt[0])
                  begin
                     state <= btft_pkg::S_LOAD;
                     strm <= strm + 11'h001;
                  end
               end
            btft_pkg::S_TRAIL:
               if (advance)
               begin
                  cnt <= cnt + 2'h1;
                  if (cnt == `BTFT_QUAD_LAST)
                     state <= btft_pkg::S_STAMP;
               end
            btft_pkg::S_STAMP:
               if (advance)
               begin
                  cnt <= cnt + 2'h1;
                  if (cnt == `BTFT_QUAD_LAST)
                     state <= btft_pkg::S_IDLE;
               end
            default:
               state <= btft_pkg::S_IDLE;
         endcase
      end
   end

   // Descriptor capture from the passing head
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cntHi <= 3'h0;
         streamCount <= 11'h000;
         desc0 <= 8'h00;
      end
      else if (stHead && advance)
      begin
         if (hdrIdx == `BTFT_POS_CNT_HI)
            cntHi <= inData[2:0];
         if (hdrIdx == `BTFT_POS_CNT_LO)
            streamCount <= {cntHi, inData};
         if (hdrIdx >= `BTFT_POS_DESC && descOff[1:0] == 2'h0)
            desc0 <= inData;
      end
   end

   // Per-stream length and sum flag table
   always_ff @(posedge clk_sys)
   begin
      if (stHead && advance && hdrIdx >= `BTFT_POS_DESC)
      begin
         if (descOff[1:0] == 2'h1)
            lenMem[descSel] <= {desc0[4:0], inData};
         if (descOff[1:0] == 2'h2)
            flagMem[descSel] <= inData[4];
      end
   end

   // Descriptor code checks and sum comparison in verify mode
   always_comb
   begin
      evSet = '0;
      if (stHead && advance && hdrIdx == `BTFT_POS_CNT_LO &&
          {cntHi, inData} > MAX_STREAMS[10:0])
         evSet[`BTFT_ST_COUNT] = 1'b1;
      if (stHead && advance && hdrIdx >= `BTFT_POS_DESC &&
          descOff[1:0] == 2'h2)
      begin
         case (dType)
            3'h0: evSet[`BTFT_ST_CODE] = dSub > 3'h2;
            3'h3: evSet[`BTFT_ST_CODE] = dSub != 3'h0;
            3'h4: evSet[`BTFT_ST_CODE] = dSub > 3'h2;
            3'h5: evSet[`BTFT_ST_CODE] = dSub > 3'h1;
            3'h7: evSet[`BTFT_ST_CODE] = 1'b0;
            default: evSet[`BTFT_ST_CODE] = 1'b1;
         endcase
         evSet[`BTFT_ST_SYNC] = dType == 3'h5 && dSub == 3'h1 &&
                                syncBlocks != 2'h0;
         evSet[`BTFT_ST_BLOCK] = dType == 3'h5 &&
            dataLen(lenMem[descSel], inData[4]) > blockCap;
      end
      evSet[`BTFT_ST_HCRC] = verify && stHcrc && advance &&
                             inData != crcSel;
      evSet[`BTFT_ST_SCRC] = verify && stScrc && advance &&
                             inData != crcSel;
   end

   // Synchronous block stream tally per frame
   always_ff @(posedge clk_sys)
   begin
      if (reset || stIdle)
         syncBlocks <= 2'h0;
      else if (stHead && advance && hdrIdx >= `BTFT_POS_DESC &&
               descOff[1:0] == 2'h2 && dType == 3'h5 && dSub == 3'h1 &&
               syncBlocks != 2'h3)
         syncBlocks <= syncBlocks + 2'h1;
   end

   // Output byte stage, held while the sink stalls
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         outValid <= 1'b0;
         outData <= 8'h00;
      end
      else if (advance)
      begin
         outValid <= 1'b1;
         outData <= byteSel;
      end
      else if (outReady)
         outValid <= 1'b0;
   end

   // Frame bookkeeping and per-frame error event
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         frameAcc <= '0;
         frameDone <= 1'b0;
         frameError <= 1'b0;
         frameCount <= 16'h0000;
         payloadLen <= 24'h000000;
         tsLatch <= 32'h00000000;
      end
      else
      begin
         frameDone <= stStamp && advance && cnt == `BTFT_QUAD_LAST;
         frameError <= stStamp && advance && cnt == `BTFT_QUAD_LAST &&
                       |(frameAcc | evSet);
         frameAcc <= stIdle ? '0 : frameAcc | evSet;
         if (stIdle)
            tsLatch <= timeStamp;
         if (stHcrc)
            payloadLen <= 24'h000000;
         else if (stLoad && strm != streamCount)
            payloadLen <= payloadLen + {11'h000, lenMem[strmSel]};
         if (stStamp && advance && cnt == `BTFT_QUAD_LAST)
            frameCount <= frameCount + 16'h0001;
      end
   end

   // APB slave: zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign apbWr = psel && penable && pwrite && !pslverr;
   assign apbSetup = psel && !penable;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ctrl <= `BTFT_CTRL_RESET;
         status <= '0;
         timeStamp <= 32'h00000000;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         status <= (status & ~((apbWr && paddr == `BTFT_REG_STATUS &&
                   pstrb[0]) ? pwdata[`BTFT_ST_W-1:0] : '0)) | evSet;
         if (apbWr && paddr == `BTFT_REG_CTRL && pstrb[0])
            ctrl <= pwdata[2:0];
         for (int b = 0; b < 4; b++)
            if (apbWr && paddr == `BTFT_REG_STAMP && pstrb[b])
               timeStamp[8*b +: 8] <= pwdata[8*b +: 8];
         if (apbSetup)
         begin
            pslverr <= 1'b0;
            case (paddr)
               `BTFT_REG_CTRL: prdata <= {29'h00000000, ctrl};
               `BTFT_REG_STATUS: prdata <= {26'h0000000, status};
               `BTFT_REG_STAMP: prdata <= timeStamp;
               `BTFT_REG_COUNT: prdata <= {frameCount, 5'h00, streamCount};
               `BTFT_REG_PAYLEN: prdata <= {8'h00, payloadLen};
               default:
               begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Checks on generated frame bytes, sequencing, count parse, output stall and sum status
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence sHcrcLast;
      stHcrc && advance && cnt[0];
   endsequence
   sequence sDataFlagEnd;
      stData && advance && remain == 13'h0001 && curFlag;
   endsequence
   a_rsv_zero: assert property (stRsv && advance && !verify |=>
      outValid && outData == 8'h00) else $error("reserved byte not zero");
   a_hcrc_high: assert property (stHcrc && advance && !cnt[0] && !verify
      |=> outData == $past(crcOut[15:8]))
      else $error("header sum high byte wrong");
   a_payload_start: assert property (sHcrcLast ##1 stLoad &&
      streamCount != 11'h000 |-> strm == 11'h000)
      else $error("payload does not start at first stream");
   a_scrc_follow: assert property (sDataFlagEnd |=> stScrc &&
      cnt == 2'h0) else $error("stream sum not after data");
   a_trail_zero: assert property (stTrail && advance && !verify |=>
      outData == 8'h00) else $error("trailer byte not zero");
   a_stamp_first: assert property (stStamp && advance && cnt == 2'h0 &&
      !verify |=> outData == tsLatch[31:24])
      else $error("stamp byte wrong");
   a_count_parse: assert property (stHead && advance &&
      hdrIdx == `BTFT_POS_CNT_LO |=> streamCount ==
      {$past(cntHi), $past(inData)}) else $error("count misparsed");
   a_hold_stall: assert property (outValid && !outReady |=> outValid &&
      $stable(outData)) else $error("output changed under stall");
   a_gen_noinput: assert property (genByte && !verify |-> !inReady)
      else $error("input taken in generated byte");
   a_sum_err: assert property (verify && stHcrc && advance &&
      inData != crcSel |=> status[`BTFT_ST_HCRC])
      else $error("header sum mismatch not flagged");

endmodule // btft_framer

`default_nettype wire

// ==== inc/btft_cfg.svh ====
`ifndef BTFT_CFG_SVH
`define BTFT_CFG_SVH

// APB register map, byte addresses
`define BTFT_ADDR_W 8
`define BTFT_REG_CTRL 8'h00
`define BTFT_REG_STATUS 8'h04
`define BTFT_REG_STAMP 8'h08
`define BTFT_REG_COUNT 8'h0C
`define BTFT_REG_PAYLEN 8'h10

// Control bits
`define BTFT_CTRL_EN 0
`define BTFT_CTRL_VERIFY 1
`define BTFT_CTRL_MODE3 2
`define BTFT_CTRL_RESET 3'h0

// Status bits, sticky, write one to clear
`define BTFT_ST_HCRC 0
`define BTFT_ST_SCRC 1
`define BTFT_ST_CODE 2
`define BTFT_ST_SYNC 3
`define BTFT_ST_BLOCK 4
`define BTFT_ST_COUNT 5
`define BTFT_ST_W 6

// Absolute byte positions inside the frame head
`define BTFT_POS_CNT_HI 14'h0006
`define BTFT_POS_CNT_LO 14'h0007
`define BTFT_POS_DESC 14'h0008
`define BTFT_POS_HCRC_FIRST 14'h000A
`define BTFT_HEAD_TAIL 14'h0007

// Block stream capacity per transmission mode
`define BTFT_BLOCKS_STD 13'h0003
`define BTFT_BLOCKS_MODE3 13'h0004

// Last index of the four-byte trailer and stamp groups
`define BTFT_QUAD_LAST 2'h3

`endif

// ==== inc/btft_pkg.sv ====
package btft_pkg;

   // Framer sequencing states, one-hot
   typedef enum logic [8:0] {
      S_IDLE  = 9'h001,
      S_HEAD  = 9'h002,
      S_RSV   = 9'h004,
      S_HCRC  = 9'h008,
      S_LOAD  = 9'h010,
      S_DATA  = 9'h020,
      S_SCRC  = 9'h040,
      S_TRAIL = 9'h080,
      S_STAMP = 9'h100
   } btft_state_t;

endpackage

// ==== hw/btft_crc16.sv ====
`timescale 1ns/1ps
`default_nettype none

module btft_crc16 #(
   parameter logic [15:0] POLY = 16'h1021,
   parameter logic [15:0] PRESET = 16'hFFFF,
   parameter bit INVERT = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Control and data
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] data,
   // Result
   output logic [15:0] crcOut
);

   logic [15:0] crc;

   // Bitwise byte update, most significant bit first
   function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] d);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         fb = r[15] ^ d[i];
         r = {r[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
      end
      return r;
   endfunction

   // Shared engine for header and stream sums
   always_ff @(posedge clk_sys)
   begin
      if (reset || init)
         crc <= PRESET;
      else if (en)
         crc <= crcByte(crc, data);
   end

   assign crcOut = INVERT ? ~crc : crc;

endmodule // btft_crc16

`default_nettype wire

// ==== verif/btft_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

module btft_sink (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Byte stream from the framer
   input wire logic [7:0] outData,
   input wire logic outValid,
   output logic outReady,
   // Pace control from the bench
   input wire logic slow
);
   logic [7:0] got[$];
   integer seed = 32'h7264;

   // Keeps each taken byte unchanged, stalls at random
   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         got.delete();
         outReady <= 1'b0;
      end
      else
      begin
         if (outValid && outReady)
            got.push_back(outData);
         outReady <= slow ? ($random(seed) % 4 == 0)
                          : ($random(seed) % 4 != 0);
      end
   end
endmodule // btft_sink

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btft_cfg.svh"

module testbench;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, slvErr;
   logic [7:0] paddr, inData, outData;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic inValid, inReady, outValid, outReady, frameDone, frameError;
   logic slow, doneSeen, errSeen;
   integer seed = 32'h7264;
   int err_count, comparisons, sumAt;
   logic [7:0] fr[$];
   logic src[$];
   logic [12:0] len[4];
   logic flg[4];
   logic [5:0] kinds[7] = '{6'o00, 6'o01, 6'o02, 6'o30, 6'o40, 6'o50, 6'o70};

   btft_framer btft_framer_inst (.clk_sys(clk_sys), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .inData(inData), .inValid(inValid),
      .inReady(inReady), .outData(outData), .outValid(outValid),
      .outReady(outReady), .frameDone(frameDone), .frameError(frameError));

   btft_sink btft_sink_inst (.clk_sys(clk_sys), .reset(reset),
      .outData(outData), .outValid(outValid), .outReady(outReady),
      .slow(slow));

   // 20 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Records the end-of-frame pulse and its error flag
   always @(posedge clk_sys)
      if (frameDone === 1'b1)
      begin
         doneSeen <= 1'b1;
         errSeen <= frameError;
      end

   task automatic chk_word(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, g);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      finish_test();
   end

   task automatic do_reset();
      reset <= 1'b1;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
   endtask

   // One APB transfer; waits for pready, takes the answer at that edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic ok;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         ok = pready;
         rd = prdata;
         slvErr = pslverr;
      end
      while (ok !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Offers one upstream byte until taken
   task automatic send(input logic [7:0] b);
      logic ok;
      inData <= b;
      inValid <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         ok = inReady;
      end
      while (ok !== 1'b1);
   endtask

   // MSB-first sum, preset all ones, inverted result
   function automatic logic [15:0] crc_of(int a, int b);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = a; i <= b; i++)
         for (int k = 7; k >= 0; k--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][k]) ? 16'h1021 : 16'h0000);
      return ~c;
   endfunction

   task automatic put(input logic [7:0] b, input logic s);
      fr.push_back(b);
      src.push_back(s);
   endtask

   // Expected frame; src marks bytes the producer supplies
   task automatic build(input int n, input logic [31:0] stamp,
                        input int bad);
      logic [5:0] kd;
      logic [15:0] c;
      int e, k;
      fr.delete();
      src.delete();
      sumAt = -1;
      for (int i = 0; i < 6; i++) put(8'($random(seed)), 1'b1);
      put(8'(n >> 8), 1'b1);
      put(8'(n), 1'b1);
      for (int s = 0; s < n; s++)
      begin
         kd = kinds[$unsigned($random(seed)) % 7];
         if (bad == 3 && s == 0)
            kd = 6'o03;
         if (bad == 4 && s < 2)
            kd = 6'o51;
         len[s] = 13'($unsigned($random(seed)) % 12);
         flg[s] = 1'($random(seed));
         if (bad != 0 && s == 0)
         begin
            len[s] = 13'h0006;
            flg[s] = 1'b1;
         end
         put({kd[5:3], len[s][12:8]}, 1'b1);
         put(len[s][7:0], 1'b1);
         put({kd[2:0], flg[s], 4'h0}, 1'b1);
         put(8'($random(seed)), 1'b1);
      end
      put(8'h00, 1'b0);
      put(8'h00, 1'b0);
      c = crc_of(10, 4 * n + 9);
      put(c[15:8], 1'b0);
      put(c[7:0], 1'b0);
      for (int s = 0; s < n; s++)
      begin
         e = (flg[s] && len[s] >= 2) ? len[s] - 2 : len[s];
         k = fr.size();
         for (int i = 0; i < e; i++)
            put(8'($random(seed)), 1'b1);
         if (e != len[s])
         begin
            if (sumAt < 0) sumAt = fr.size();
            c = crc_of(k, k + e - 1);
            put(c[15:8], 1'b0);
            put(c[7:0], 1'b0);
         end
      end
      for (int i = 0; i < 4; i++) put(8'h00, 1'b0);
      for (int i = 0; i < 4; i++) put(stamp[31 - 8 * i -: 8], 1'b0);
   endtask

   // One frame: bad 1 spoils the header sum, 2 a stream sum,
   // 3 uses a reserved subtype, 4 sends two synchronous block streams
   task automatic run_frame(input logic v, input int n, input int bad,
                            input logic [31:0] expSt);
      int m, at;
      logic [31:0] stamp;
      stamp = $random(seed);
      build(n, stamp, bad);
      m = 0;
      for (int s = 0; s < n; s++) m += len[s];
      at = (bad == 1) ? 4 * n + 10 : (bad == 2) ? sumAt : -1;
      if (at >= 0) fr[at] = ~fr[at];
      apb(1'b1, `BTFT_REG_STAMP, stamp);
      apb(1'b1, `BTFT_REG_CTRL, {30'h0, v, 1'b1});
      doneSeen = 1'b0;
      errSeen = 1'b0;
      for (int i = 0; i < fr.size(); i++)
         if (v || src[i]) send(fr[i]);
      inValid <= 1'b0;
      for (int i = 0; i < 400 && !doneSeen; i++) @(posedge clk_sys);
      repeat (40) @(posedge clk_sys);
      chk_bit("frame done", 1'b1, doneSeen);
      chk_bit("frame error", expSt != 0, errSeen);
      chk_word("frame length", 32'(fr.size()),
               32'(btft_sink_inst.got.size()));
      for (int i = 0; i < fr.size() && i < btft_sink_inst.got.size(); i++)
         chk_word("frame byte", fr[i],
                  btft_sink_inst.got[i]);
      apb(1'b0, `BTFT_REG_STATUS, 32'h0);
      chk_word("status", expSt, rd);
      apb(1'b1, `BTFT_REG_STATUS, 32'h0000003F);
      apb(1'b0, `BTFT_REG_STATUS, 32'h0);
      chk_word("status cleared", 32'h0, rd);
      apb(1'b0, `BTFT_REG_COUNT, 32'h0);
      chk_word("stream count", 32'(n), {21'h0, rd[10:0]});
      chk_word("frame count", 32'h1, {16'h0, rd[31:16]});
      apb(1'b0, `BTFT_REG_PAYLEN, 32'h0);
      chk_word("payload length", 32'(m), {8'h0, rd[23:0]});
      $display("frame test done: verify %0d streams %0d", v, n);
      do_reset();
   endtask

   // Main sequence
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      inData = 8'h00;
      inValid = 1'b0;
      slow = 1'b0;
      doneSeen = 1'b0;
      errSeen = 1'b0;
      do_reset();
      apb(1'b0, `BTFT_REG_CTRL, 32'h0);
      chk_word("ctrl reset", 32'h0, rd);
      apb(1'b0, `BTFT_REG_STATUS, 32'h0);
      chk_word("status reset", 32'h0, rd);
      apb(1'b0, 8'h14, 32'h0);
      chk_bit("unmapped error", 1'b1, slvErr);
      chk_word("unmapped read", 32'h0, rd);
      apb(1'b1, `BTFT_REG_CTRL, 32'h00000006);
      apb(1'b0, `BTFT_REG_CTRL, 32'h0);
      chk_word("ctrl readback", 32'h00000006, rd);
      apb(1'b1, `BTFT_REG_CTRL, 32'h0);
      $display("register test done");
      run_frame(1'b0, 0, 0, 32'h0);
      for (int t = 0; t < 6; t++)
      begin
         slow <= t[0];
         run_frame(1'b0, 1 + $unsigned($random(seed)) % 3, 0, 32'h0);
      end
      run_frame(1'b1, 2, 0, 32'h0);
      run_frame(1'b1, 2, 1, 32'h00000001);
      run_frame(1'b1, 2, 2, 32'h00000002);
      run_frame(1'b0, 2, 3, 32'h00000004);
      run_frame(1'b0, 2, 4, 32'h00000008);
      finish_test();
   end
endmodule // testbench

`default_nettype wire
